// ### hdl/ntwpd_top.sv
// nfc target wake-up, protocol detect, framer and shared fifo with apb registers
// Behaviour
// [R1] field measurement on only with nonzero level
// [R2] field above level forces chip enable
// [R3] stable oscillator sets flag and field irq
// [R4] protocol bit 7 shows live field detect
// [R5] first command raises receive-start irq
// [R6] host raises enable between the two irqs
// [R7] protocol and rate stored after first command
// [R8] sens or all request selects passive 106
// [R9] auto-sdd clear forwards command to fifo
// [R10] field loss raises field irq, aborts
// [R11] clock extractor on for passive 106, emulation
// [R12] request with emulation bit emulates type a
// [R13] sensf request selects passive 212/424
// [R14] atr request selects active target
// [R15] host checks field before active transmit
// [R16] sensb with emulation enters type b emulation
// [R17] framed payload shared through 127-byte fifo
// [R18] receive framer checks parity, packs bytes
// [R19] transmit adds start, end, parity bits
// [R20] initiator transmits only after collision avoidance
// [R21] direct modes 0/1 bypass framing
`timescale 1ns/1ps
`include "ntwpd_consts.svh"
module ntwpd_top #(
   parameter int DEPTH  = `NTWPD_FIFO_DEPTH,
   parameter int CA_CYC = `NTWPD_CA_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   input  wire logic                 chip_en_pin,
   input  wire logic                 supply_hold_select_pin,
   input  wire logic [2:0]           rf_level,
   input  wire logic                 osc_stable,
   input  wire logic                 ext_field,
   input  wire logic                 subcarrier,
   input  wire ntwpd_pkg::ntwpd_link_type  rx_link,
   input  wire ntwpd_pkg::ntwpd_first_type first_cmd,
   output logic                      irq,
   output logic                      meas_en,
   output logic                      chip_en_forced,
   output logic                      supply_on,
   output logic                      clk_extract_en,
   output logic                      tx_bit,
   output logic                      tx_active,
   output logic                      direct_data,
   output logic                      direct_clk
);
   localparam int TXC = `NTWPD_TX_BIT_CYC;

   ntwpd_pkg::ntwpd_state_type st_q;
   ntwpd_pkg::ntwpd_proto_type proto_q;
   logic [7:0]  det_q;
   logic [7:0]  iso_q;
   logic [7:0]  irq_q;
   logic        osc_ok_q;
   logic [1:0]  rate_q;
   logic [2:0]  lvl_s1, lvl_s2;
   logic [1:0]  osc_s, ext_s, sub_s, cen_s, hold_s;
   logic [2:0]  lk_s1, lk_s2;
   logic        lk_clk_d;
   logic        rf_det;
   logic        rx_edge;
   logic [7:0]  mem [0:DEPTH-1];
   logic [6:0]  wr_q, rd_q;
   logic [7:0]  cnt_q;
   logic        ovf_q;
   logic        push, pop, tx_pop;
   logic [7:0]  push_data;
   logic [7:0]  rx_sh_q;
   logic [3:0]  rx_n_q;
   logic        rx_push;
   logic        rx_err;
   logic        ca_busy_q, ca_ok_q;
   logic [15:0] ca_cnt_q;
   logic        ca_fail;
   logic [3:0]  tx_idx_q;
   logic [7:0]  tx_sh_q;
   logic [7:0]  tx_tick_q;
   logic        tx_go;
   logic        acc, wr_acc, rd_acc, mapped;
   logic        rf_drop, first_hit;
   logic        direct;

   // pointer step with wrap at fifo depth
   function automatic logic [6:0] ptr_inc(input logic [6:0] p);
      ptr_inc = (p == 7'(DEPTH - 1)) ? 7'h0 : p + 7'h1;
   endfunction : ptr_inc

   // odd parity bit of a byte
   function automatic logic odd_par(input logic [7:0] b);
      odd_par = ~(^b);
   endfunction : odd_par

   // two-stage synchronisers for pins
   always_ff @(posedge clk) begin
      if (rst) begin
         lvl_s1 <= 3'h0;
         lvl_s2 <= 3'h0;
         osc_s  <= 2'h0;
         ext_s  <= 2'h0;
         sub_s  <= 2'h0;
         cen_s  <= 2'h0;
         hold_s <= 2'h0;
         lk_s1  <= 3'h0;
         lk_s2  <= 3'h0;
         lk_clk_d <= 1'b0;
      end else begin
         lvl_s1 <= rf_level;
         lvl_s2 <= lvl_s1;
         osc_s  <= {osc_s[0], osc_stable};
         ext_s  <= {ext_s[0], ext_field};
         sub_s  <= {sub_s[0], subcarrier};
         cen_s  <= {cen_s[0], chip_en_pin};
         hold_s <= {hold_s[0], supply_hold_select_pin};
         lk_s1  <= rx_link;
         lk_s2  <= lk_s1;
         lk_clk_d <= lk_s2[2];
      end
   end

   // field detect and wake request
   assign meas_en = det_q[`NTWPD_DET_LVL_HI:`NTWPD_DET_LVL_LO] != 3'h0; // R1
   assign rf_det  = meas_en && (lvl_s2 > det_q[2:0]); // R2
   assign rx_edge = lk_s2[2] & ~lk_clk_d;
   assign direct  = iso_q[`NTWPD_ISO_DIRECT];
   assign rf_drop = !rf_det && st_q != ntwpd_pkg::ST_SLEEP;
   assign first_hit = first_cmd.valid && st_q == ntwpd_pkg::ST_ARMED;

   // wake-up sequence
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= ntwpd_pkg::ST_SLEEP;
      end else begin
         case (st_q)
            ntwpd_pkg::ST_SLEEP: begin
               if (rf_det) begin
                  st_q <= ntwpd_pkg::ST_WAKE; // R2
               end
            end
            ntwpd_pkg::ST_WAKE: begin
               if (rf_drop) begin
                  st_q <= ntwpd_pkg::ST_SLEEP; // R10
               end else if (osc_s[1]) begin
                  st_q <= ntwpd_pkg::ST_ARMED;
               end
            end
            ntwpd_pkg::ST_ARMED: begin
               if (rf_drop) begin
                  st_q <= ntwpd_pkg::ST_SLEEP; // R10
               end else if (first_cmd.valid) begin
                  st_q <= ntwpd_pkg::ST_TARGET;
               end
            end
            ntwpd_pkg::ST_TARGET: begin
               if (rf_drop) begin
                  st_q <= ntwpd_pkg::ST_SLEEP; // R10
               end
            end
            default: st_q <= ntwpd_pkg::ST_SLEEP;
         endcase
      end
   end

   // forced enable ends with the receive-start irq, host holds its own
   assign chip_en_forced = st_q == ntwpd_pkg::ST_WAKE
                        || st_q == ntwpd_pkg::ST_ARMED; // R2 R6
   assign supply_on = cen_s[1] | chip_en_forced | hold_s[1];
   assign clk_extract_en = st_q == ntwpd_pkg::ST_TARGET
                        && (proto_q == ntwpd_pkg::PR_PAS106
                        || proto_q == ntwpd_pkg::PR_EMU_A
                        || proto_q == ntwpd_pkg::PR_EMU_B); // R11

   // oscillator stable flag
   always_ff @(posedge clk) begin
      if (rst) begin
         osc_ok_q <= 1'b0;
      end else begin
         osc_ok_q <= osc_s[1] && supply_on; // R3
      end
   end

   // protocol and rate from the first command
   always_ff @(posedge clk) begin
      if (rst) begin
         proto_q <= ntwpd_pkg::PR_NONE;
         rate_q  <= 2'h0;
      end else if (rf_drop) begin
         proto_q <= ntwpd_pkg::PR_NONE;
         rate_q  <= 2'h0; // R10
      end else if (first_hit) begin
         rate_q <= first_cmd.rate; // R7
         case (ntwpd_pkg::ntwpd_cmd_type'(first_cmd.code))
            ntwpd_pkg::CMD_SENS, ntwpd_pkg::CMD_ALL: begin
               proto_q <= iso_q[`NTWPD_ISO_CARDEMU] ? ntwpd_pkg::PR_EMU_A // R12
                                                    : ntwpd_pkg::PR_PAS106; // R8
               rate_q  <= 2'h0;
            end
            ntwpd_pkg::CMD_SENSF: proto_q <= ntwpd_pkg::PR_PASHI; // R13
            ntwpd_pkg::CMD_ATR:   proto_q <= ntwpd_pkg::PR_ACTIVE; // R14
            ntwpd_pkg::CMD_SENSB: begin
               if (iso_q[`NTWPD_ISO_CARDEMU]) begin
                  proto_q <= ntwpd_pkg::PR_EMU_B; // R16
               end
            end
            default: proto_q <= ntwpd_pkg::PR_NONE;
         endcase
      end else if (first_cmd.valid && st_q == ntwpd_pkg::ST_TARGET) begin
         rate_q <= first_cmd.rate; // R7
      end
   end

   // receive framer: start bit, 8 data bits, odd parity, bytes out
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_sh_q <= 8'h00;
         rx_n_q  <= 4'h0;
      end else if (!lk_s2[0] || direct) begin
         rx_n_q <= 4'h0; // R18 R21
      end else if (rx_edge) begin
         if (rx_n_q == 4'h0) begin
            rx_n_q <= lk_s2[1] ? 4'h1 : 4'h0; // R18
         end else if (rx_n_q == 4'h9) begin
            rx_n_q <= 4'h0;
         end else begin
            rx_sh_q <= {lk_s2[1], rx_sh_q[7:1]};
            rx_n_q  <= rx_n_q + 4'h1;
         end
      end
   end

   assign rx_err  = rx_edge && lk_s2[0] && !direct && rx_n_q == 4'h9
                 && lk_s2[1] != odd_par(rx_sh_q); // R18
   assign rx_push = rx_edge && lk_s2[0] && !direct && rx_n_q == 4'h9
                 && !rx_err && st_q != ntwpd_pkg::ST_SLEEP
                 && !(det_q[`NTWPD_DET_AUTOSDD]
                 && proto_q == ntwpd_pkg::PR_PAS106); // R9

   // apb decode, zero wait states
   assign acc    = psel && penable;
   assign pready = 1'b1;
   assign mapped = paddr[1:0] == 2'h0 && paddr <= `NTWPD_ADR_CMD;
   assign wr_acc = acc && pwrite && mapped;
   assign rd_acc = acc && !pwrite && mapped;
   assign pslverr = acc && !mapped;

   // shared fifo, receive push wins over a register write
   assign push      = rx_push || (wr_acc && paddr == `NTWPD_ADR_FIFO);
   assign push_data = rx_push ? rx_sh_q : pwdata[7:0];
   assign pop       = tx_pop || (rd_acc && paddr == `NTWPD_ADR_FIFO && !tx_active);
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q  <= 7'h0;
         rd_q  <= 7'h0;
         cnt_q <= 8'h00;
         ovf_q <= 1'b0;
      end else begin
         if (push && cnt_q != 8'(DEPTH)) begin
            mem[wr_q] <= push_data; // R17
            wr_q <= ptr_inc(wr_q);
         end
         if (pop && cnt_q != 8'h00) begin
            rd_q <= ptr_inc(rd_q);
         end
         cnt_q <= cnt_q + 8'((push && cnt_q != 8'(DEPTH)) ? 1 : 0)
                        - 8'((pop && cnt_q != 8'h00) ? 1 : 0);
         if (push && cnt_q == 8'(DEPTH)) begin
            ovf_q <= 1'b1;
         end else if (wr_acc && paddr == `NTWPD_ADR_FSTAT) begin
            ovf_q <= 1'b0;
         end
      end
   end

   // collision avoidance: field must stay absent for CA_CYC
   assign ca_fail = ca_busy_q && ext_s[1];
   always_ff @(posedge clk) begin
      if (rst) begin
         ca_busy_q <= 1'b0;
         ca_ok_q   <= 1'b0;
         ca_cnt_q  <= 16'h0000;
      end else if (wr_acc && paddr == `NTWPD_ADR_CMD
                   && pwdata[`NTWPD_CMD_CA]) begin
         ca_busy_q <= 1'b1; // R20
         ca_ok_q   <= 1'b0;
         ca_cnt_q  <= 16'h0000;
      end else if (ca_fail) begin
         ca_busy_q <= 1'b0;
      end else if (ca_busy_q) begin
         ca_cnt_q <= ca_cnt_q + 16'h0001;
         if (ca_cnt_q == 16'(CA_CYC - 1)) begin
            ca_busy_q <= 1'b0;
            ca_ok_q   <= 1'b1; // R20
         end
      end else if (tx_active && tx_idx_q == 4'hB && tx_tick_q == 8'h00) begin
         ca_ok_q <= 1'b0;
      end
   end

   // transmit encoder: start, data, parity per byte, end bit
   assign tx_go  = wr_acc && paddr == `NTWPD_ADR_CMD && pwdata[`NTWPD_CMD_TX]
                && !tx_active && !direct && cnt_q != 8'h00
                && (ca_ok_q || st_q == ntwpd_pkg::ST_TARGET); // R20
   assign tx_pop = tx_active && tx_tick_q == 8'h00 && tx_idx_q == 4'h9
                && cnt_q != 8'h00;
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_active <= 1'b0;
         tx_idx_q  <= 4'h0;
         tx_sh_q   <= 8'h00;
         tx_tick_q <= 8'h00;
         tx_bit    <= 1'b0;
      end else if (tx_go) begin
         tx_active <= 1'b1;
         tx_idx_q  <= 4'h0;
         tx_sh_q   <= mem[rd_q];
         tx_tick_q <= 8'(TXC - 1);
         tx_bit    <= 1'b1; // R19
      end else if (tx_active) begin
         if (tx_tick_q != 8'h00) begin
            tx_tick_q <= tx_tick_q - 8'h01;
         end else begin
            tx_tick_q <= 8'(TXC - 1);
            case (tx_idx_q)
               4'h8: begin
                  tx_bit   <= odd_par(tx_sh_q); // R19
                  tx_idx_q <= 4'h9;
               end
               4'h9: begin
                  if (cnt_q > 8'h01) begin
                     tx_sh_q  <= mem[ptr_inc(rd_q)];
                     tx_bit   <= 1'b1;
                     tx_idx_q <= 4'h0;
                  end else begin
                     tx_bit   <= 1'b0; // R19
                     tx_idx_q <= 4'hB;
                  end
               end
               4'hB: begin
                  tx_active <= 1'b0;
                  tx_bit    <= 1'b0;
                  tx_idx_q  <= 4'h0;
               end
               default: begin
                  tx_bit   <= tx_sh_q[tx_idx_q[2:0]];
                  tx_idx_q <= tx_idx_q + 4'h1;
               end
            endcase
         end
      end
   end

   // direct modes: raw subcarrier or unframed bit with clock
   always_ff @(posedge clk) begin
      if (rst) begin
         direct_data <= 1'b0;
         direct_clk  <= 1'b0;
      end else if (!direct) begin
         direct_data <= 1'b0;
         direct_clk  <= 1'b0;
      end else if (!iso_q[`NTWPD_ISO_DMODE]) begin
         direct_data <= sub_s[1]; // R21
         direct_clk  <= 1'b0;
      end else begin
         direct_data <= lk_s2[1]; // R21
         direct_clk  <= lk_s2[2];
      end
   end

   // configuration registers
   always_ff @(posedge clk) begin
      if (rst) begin
         det_q <= 8'h00;
         iso_q <= 8'h00;
      end else if (wr_acc && paddr == `NTWPD_ADR_DETECT) begin
         det_q <= pwdata[7:0];
      end else if (wr_acc && paddr == `NTWPD_ADR_ISOCTL) begin
         iso_q <= pwdata[7:0];
      end
   end

   // irq status, cleared by read, a new event wins
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_q <= 8'h00;
      end else begin
         irq_q <= (rd_acc && paddr == `NTWPD_ADR_IRQ) ? 8'h00 : irq_q;
         if ((st_q == ntwpd_pkg::ST_WAKE && osc_s[1]) || rf_drop) begin
            irq_q[`NTWPD_IRQ_FIELD] <= 1'b1; // R3 R10
         end
         if (first_hit) begin
            irq_q[`NTWPD_IRQ_RXSTART] <= 1'b1; // R5
         end
         if (rx_err) begin
            irq_q[`NTWPD_IRQ_RXERR] <= 1'b1;
         end
         if (ca_fail) begin
            irq_q[`NTWPD_IRQ_CAFAIL] <= 1'b1;
         end
      end
   end
   assign irq = irq_q != 8'h00;

   // read data mux
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_acc) begin
         case (paddr)
            `NTWPD_ADR_DETECT: prdata[7:0] = det_q;
            `NTWPD_ADR_ISOCTL: prdata[7:0] = iso_q;
            `NTWPD_ADR_OSC:    prdata[`NTWPD_OSC_OK] = osc_ok_q; // R3
            `NTWPD_ADR_IRQ:    prdata[7:0] = irq_q;
            `NTWPD_ADR_PROTO:  prdata[7:0] = {rf_det, 2'h0, rate_q, proto_q}; // R4 R7
            `NTWPD_ADR_FIFO:   prdata[7:0] = mem[rd_q];
            `NTWPD_ADR_FSTAT:  prdata[8:0] = {ovf_q, cnt_q};
            `NTWPD_ADR_CMD:    prdata[1:0] = {tx_active, ca_ok_q};
            default:           prdata = 32'h0000_0000;
         endcase
      end
   end
endmodule : ntwpd_top

// ### shared/ntwpd_consts.svh
// register offsets, field positions and timing counts for the target wake-up block
`ifndef NTWPD_CONSTS_SVH
`define NTWPD_CONSTS_SVH
`define NTWPD_ADR_DETECT   8'h00
`define NTWPD_ADR_ISOCTL   8'h04
`define NTWPD_ADR_OSC      8'h08
`define NTWPD_ADR_IRQ      8'h0C
`define NTWPD_ADR_PROTO    8'h10
`define NTWPD_ADR_FIFO     8'h14
`define NTWPD_ADR_FSTAT    8'h18
`define NTWPD_ADR_CMD      8'h1C
`define NTWPD_DET_LVL_LO   0
`define NTWPD_DET_LVL_HI   2
`define NTWPD_DET_AUTOSDD  5
`define NTWPD_ISO_CARDEMU  0
`define NTWPD_ISO_DIRECT   1
`define NTWPD_ISO_DMODE    2
`define NTWPD_OSC_OK       6
`define NTWPD_IRQ_FIELD    2
`define NTWPD_IRQ_RXERR    4
`define NTWPD_IRQ_CAFAIL   5
`define NTWPD_IRQ_RXSTART  6
`define NTWPD_PROTO_RF     7
`define NTWPD_CMD_CA       0
`define NTWPD_CMD_TX       1
`define NTWPD_FIFO_DEPTH   127
`define NTWPD_CLK_NS       50
`define NTWPD_TX_BIT_NS    400
`define NTWPD_TX_BIT_CYC   ((`NTWPD_TX_BIT_NS) / (`NTWPD_CLK_NS))
`define NTWPD_CA_NS        20000
`define NTWPD_CA_CYC       (((`NTWPD_CA_NS) + (`NTWPD_CLK_NS) - 1) / (`NTWPD_CLK_NS))
`endif

// ### shared/ntwpd_pkg.sv
// types of the target wake-up and protocol detect block
package ntwpd_pkg;
   typedef enum logic [1:0] {
      ST_SLEEP  = 2'b00,
      ST_WAKE   = 2'b01,
      ST_ARMED  = 2'b11,
      ST_TARGET = 2'b10
   } ntwpd_state_type;
   typedef enum logic [2:0] {
      CMD_SENS   = 3'h1,
      CMD_ALL    = 3'h2,
      CMD_SENSF  = 3'h3,
      CMD_ATR    = 3'h4,
      CMD_SENSB  = 3'h5
   } ntwpd_cmd_type;
   typedef enum logic [2:0] {
      PR_NONE    = 3'h0,
      PR_PAS106  = 3'h1,
      PR_EMU_A   = 3'h2,
      PR_PASHI   = 3'h3,
      PR_ACTIVE  = 3'h4,
      PR_EMU_B   = 3'h5
   } ntwpd_proto_type;
   typedef struct packed {
      logic clk;
      logic data;
      logic frame;
   } ntwpd_link_type;
   typedef struct packed {
      logic [2:0] code;
      logic [1:0] rate;
      logic       valid;
   } ntwpd_first_type;
endpackage : ntwpd_pkg

// ### test/ntwpd_rf_model.sv
// behavioural decoder side that feeds framed bits on the receive link
`timescale 1ns/1ps
module ntwpd_rf_model (
   output ntwpd_pkg::ntwpd_link_type link
);
   // link idles with clock low and no frame
   initial begin
      link = '0;
   end
   // one frame: start bit, data lsb first, parity; bad flips parity
   task send(input logic [7:0] b, input logic bad);
      logic [9:0] bits;
      bits = {~^b ^ bad, b, 1'b1};
      #7 link.frame = 1'b1;
      for (int k = 0; k < 10; k++) begin
         link.data = bits[k];
         #200 link.clk = 1'b1;
         #200 link.clk = 1'b0;
      end
      #200 link.frame = 1'b0;
      link.data = ~link.data; // released line shows no stale value
   endtask : send
endmodule : ntwpd_rf_model

// ### test/ntwpd_props.sv
// port assertions for the target wake-up block
`timescale 1ns/1ps
`include "ntwpd_consts.svh"
module ntwpd_props #(
   parameter int DEPTH  = `NTWPD_FIFO_DEPTH,
   parameter int CA_CYC = `NTWPD_CA_CYC
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        chip_en_pin,
   input wire logic        supply_hold_select_pin,
   input wire logic        irq,
   input wire logic        meas_en,
   input wire logic        chip_en_forced,
   input wire logic        supply_on,
   input wire logic        clk_extract_en,
   input wire logic        tx_bit,
   input wire logic        tx_active,
   input wire logic        direct_data,
   input wire logic        direct_clk
);
   logic [2:0] lvl_q;
   logic       dir_q;
   logic       acc;
   assign acc = psel && penable;
   // shadow of the wake level field
   always_ff @(posedge clk) begin
      if (rst) begin
         lvl_q <= 3'h0;
      end else if (acc && pwrite && paddr == `NTWPD_ADR_DETECT) begin
         lvl_q <= pwdata[2:0];
      end
   end
   // shadow of the direct enable bit
   always_ff @(posedge clk) begin
      if (rst) begin
         dir_q <= 1'b0;
      end else if (acc && pwrite && paddr == `NTWPD_ADR_ISOCTL) begin
         dir_q <= pwdata[`NTWPD_ISO_DIRECT];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // transmit begins with a full start bit
   sequence tx_go_s;
      $rose(tx_active);
   endsequence
   sequence start_bit_s;
      (tx_active && tx_bit) [*8];
   endsequence
   // checks
   meas_level_a: assert property (meas_en == (lvl_q != 3'h0))
      else $error("measurement enable wrong");
   supply_or_a: assert property (supply_on == ($past(chip_en_pin, 2) || chip_en_forced
      || $past(supply_hold_select_pin, 2))) else $error("supply enable wrong");
   force_drop_a: assert property ($fell(chip_en_forced) |-> irq)
      else $error("forced enable dropped without irq");
   extract_target_a: assert property (clk_extract_en |-> !chip_en_forced)
      else $error("clock extractor on outside target");
   direct_off_a: assert property (!dir_q && !$past(dir_q) |-> !direct_data && !direct_clk)
      else $error("direct outputs active while off");
   tx_start_a: assert property (tx_go_s |-> start_bit_s)
      else $error("start bit wrong");
   tx_end_a: assert property ($fell(tx_active) |-> !$past(tx_bit))
      else $error("end bit wrong");
   bad_addr_a: assert property (acc && (paddr > 8'h1C || paddr[1:0] != 2'b00)
      |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
   idle_bus_a: assert property (!acc |-> !pslverr && prdata == 32'h0000_0000)
      else $error("bus outputs outside access");
   zero_wait_a: assert property (acc |-> pready)
      else $error("ready missing");
endmodule : ntwpd_props
bind ntwpd_top ntwpd_props #(.DEPTH(DEPTH), .CA_CYC(CA_CYC)) ntwpd_props_inst (.*);

// ### test/ntwpd_top_bench.sv
// self-checking bench for the target wake-up block
`timescale 1ns/1ps
`include "ntwpd_consts.svh"
module ntwpd_top_bench;
   localparam int CA = 4;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic        pready, pslverr, err, chip_en_pin = 1'b0, supply_hold_select_pin = 1'b0;
   logic [2:0]  rf_level = 3'h0;
   logic        osc_stable = 1'b0, ext_field = 1'b0, subcarrier = 1'b0;
   ntwpd_pkg::ntwpd_link_type  rx_link;
   ntwpd_pkg::ntwpd_first_type first_cmd = '0;
   logic        irq, meas_en, chip_en_forced, supply_on, clk_extract_en;
   logic        tx_bit, tx_active, direct_data, direct_clk;
   logic [3:0]  w;
   logic [10:0] txe;
   logic [1:0]  rt;
   logic [5:0]  emu_t = 6'h12;
   logic [2:0]  code_t [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5};
   logic [2:0]  exp_t [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
   int          fail_count = 0, checks = 0, i, k;
   // clock and wait conditions
   always #25 clk = ~clk;
   assign w = {direct_clk, ~tx_active, tx_active, irq};
   ntwpd_top #(.CA_CYC(CA)) ntwpd_top_inst (.*);
   ntwpd_rf_model ntwpd_rf_model_inst (.link(rx_link));
   // value and flag compares
   task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %h seen %h", n, e, g);
      end
   endtask : cmp
   task cmpb(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %b seen %b", n, e, g);
      end
   endtask : cmpb
   // one apb transfer, answer taken at the pready edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk);
   endtask : apb
   task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0000_0000);
      cmp(n, e, rd);
   endtask : rdc
   task wait_on(input int s);
      for (int n = 0; n < 400 && w[s] !== 1'b1; n++) @(negedge clk);
      if (w[s] !== 1'b1) begin
         fail_count++;
         $display("MISMATCH wait %0d exp 1 seen 0", s);
         end_sim;
      end
   endtask : wait_on
   task end_sim;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim
   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      end_sim;
   end
   // test sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rdc(`NTWPD_ADR_IRQ, 32'h0000_0000, "irq rst");
      rdc(`NTWPD_ADR_FSTAT, 32'h0000_0000, "fstat rst");
      rdc(8'h20, 32'h0000_0000, "unmapped");
      cmpb("unmapped err", 1'b1, err);
      apb(1'b1, 8'h22, 32'h0000_0007);
      cmpb("unaligned err", 1'b1, err);
      cmpb("meas off", 1'b0, meas_en);
      apb(1'b1, `NTWPD_ADR_DETECT, 32'h0000_0003);
      cmpb("meas on", 1'b1, meas_en);
      $display("test reset done");
      for (i = 0; i < 6; i++) begin
         apb(1'b1, `NTWPD_ADR_ISOCTL, 32'(emu_t[i]));
         @(posedge clk);
         rf_level <= 3'h5;
         osc_stable <= 1'b1;
         wait_on(0);
         cmpb("forced", 1'b1, chip_en_forced);
         rdc(`NTWPD_ADR_IRQ, 32'h0000_0004, "wake irq");
         rdc(`NTWPD_ADR_OSC, 32'h0000_0040, "osc ok");
         rdc(`NTWPD_ADR_PROTO, 32'h0000_0080, "live rf");
         @(posedge clk);
         chip_en_pin <= 1'b1;
         first_cmd <= {code_t[i], 2'(i), 1'b1};
         @(posedge clk);
         first_cmd.valid <= 1'b0;
         wait_on(0);
         rdc(`NTWPD_ADR_IRQ, 32'h0000_0040, "rx start");
         rt = (exp_t[i] inside {3'h1, 3'h2}) ? 2'h0 : 2'(i);
         rdc(`NTWPD_ADR_PROTO, {24'h00_0000, 3'h4, rt, exp_t[i]}, "proto");
         cmpb("forced off", 1'b0, chip_en_forced);
         cmpb("extract", exp_t[i] inside {3'h1, 3'h2, 3'h5}, clk_extract_en);
         if (i == 1) begin
            @(posedge clk);
            first_cmd <= {code_t[i], 2'h2, 1'b1};
            @(posedge clk);
            first_cmd.valid <= 1'b0;
            rdc(`NTWPD_ADR_PROTO, 32'h0000_0092, "rate change");
         end
         if (i == 0) begin
            ntwpd_rf_model_inst.send(8'hA5, 1'b0);
            rdc(`NTWPD_ADR_FSTAT, 32'h0000_0001, "rx count");
            rdc(`NTWPD_ADR_FIFO, 32'h0000_00A5, "rx byte");
            ntwpd_rf_model_inst.send(8'h3C, 1'b1);
            wait_on(0);
            rdc(`NTWPD_ADR_IRQ, 32'h0000_0010, "parity irq");
            rdc(`NTWPD_ADR_FSTAT, 32'h0000_0000, "bad dropped");
            apb(1'b1, `NTWPD_ADR_FIFO, 32'h0000_005A);
            apb(1'b1, `NTWPD_ADR_CMD, 32'h0000_0002);
            txe = {1'b0, ~^8'h5A, 8'h5A, 1'b1};
            wait_on(1);
            for (k = 0; k < 11; k++) begin
               repeat (4) @(negedge clk);
               cmpb("tx bit", txe[k], tx_bit);
               repeat (4) @(negedge clk);
            end
            cmpb("tx done", 1'b0, tx_active);
         end
         @(posedge clk);
         rf_level <= 3'h0;
         wait_on(0);
         rdc(`NTWPD_ADR_IRQ, 32'h0000_0004, "field loss");
         rdc(`NTWPD_ADR_PROTO, 32'h0000_0000, "proto clr");
         $display("test first command %0d done", i);
      end
      apb(1'b1, `NTWPD_ADR_FIFO, 32'h0000_00C3);
      apb(1'b1, `NTWPD_ADR_CMD, 32'h0000_0002);
      repeat (10) @(negedge clk);
      cmpb("tx refused", 1'b0, tx_active);
      apb(1'b1, `NTWPD_ADR_CMD, 32'h0000_0001);
      repeat (CA + 10) @(posedge clk);
      rdc(`NTWPD_ADR_CMD, 32'h0000_0001, "ca ok");
      apb(1'b1, `NTWPD_ADR_CMD, 32'h0000_0002);
      wait_on(1);
      cmpb("tx after ca", 1'b1, tx_active);
      wait_on(2);
      rdc(`NTWPD_ADR_FSTAT, 32'h0000_0000, "fifo drained");
      @(posedge clk);
      ext_field <= 1'b1;
      apb(1'b1, `NTWPD_ADR_CMD, 32'h0000_0001);
      wait_on(0);
      rdc(`NTWPD_ADR_IRQ, 32'h0000_0020, "ca fail");
      $display("test collision avoidance done");
      apb(1'b1, `NTWPD_ADR_ISOCTL, 32'h0000_0002);
      @(posedge clk);
      subcarrier <= 1'b1;
      repeat (6) @(negedge clk);
      cmpb("direct 0", 1'b1, direct_data);
      apb(1'b1, `NTWPD_ADR_ISOCTL, 32'h0000_0006);
      fork
         ntwpd_rf_model_inst.send(8'hFF, 1'b0);
      join_none
      wait_on(3);
      cmpb("direct 1 clk", 1'b1, direct_clk);
      repeat (120) @(posedge clk);
      rdc(`NTWPD_ADR_FSTAT, 32'h0000_0000, "bypass");
      apb(1'b1, `NTWPD_ADR_ISOCTL, 32'h0000_0000);
      repeat (3) @(negedge clk);
      cmpb("direct off", 1'b0, direct_data);
      $display("test direct done");
      end_sim;
   end
endmodule : ntwpd_top_bench
